// ==== rtl/ubt_pkg.sv ====
// Purpose: Shared constants and types for the serial base clock and transmitter
// Assumes: Byte-wide register port, one clock domain
// Notes: Register offsets, fields and reset values live here, except the buffer reset value set in ubt_top
`default_nettype none

package ubt_pkg;

  localparam logic [15:0] ADDR_CLK_SEL = 16'hff56;
  localparam logic [15:0] ADDR_MODE = 16'hff50;
  localparam logic [15:0] ADDR_TXB = 16'hff51;
  localparam logic [15:0] ADDR_DIV = 16'hff52;
  localparam logic [15:0] ADDR_STAT = 16'hff53;
  localparam logic [15:0] ADDR_MASK = 16'hff54;

  localparam logic [3:0] CLK_SEL_RST = 4'h0;
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [7:0] DIV_RST = 8'h00;
  localparam logic [1:0] MASK_RST = 2'h0;
  localparam logic [1:0] STAT_RST = 2'h0;

  localparam logic [3:0] SEL_DIV_MAX = 4'ha;
  localparam logic [3:0] SEL_TIMER = 4'hb;
  localparam int DIV_CNT_W = 10;

  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_OVR_BIT = 1;
  localparam int STAT_BUSY_BIT = 7;
  localparam logic [2:0] LAST_DATA_IDX = 3'h7;

  typedef enum logic [1:0] {
    PAR_NONE = 2'h0,
    PAR_ZERO = 2'h1,
    PAR_ODD = 2'h2,
    PAR_EVEN = 2'h3
  } ubt_parity_type;

  // Mode register: bit 7 power, bit 6 transmit enable, bits 4:3 parity, bit 2 two stop bits
  typedef struct packed {
    logic power;
    logic txe;
    logic rsvd_hi;
    ubt_parity_type parity;
    logic stop2;
    logic [1:0] rsvd_lo;
  } ubt_mode_type;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ubt_bus_type;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_START = 5'h02,
    ST_DATA = 5'h04,
    ST_PARITY = 5'h08,
    ST_STOP = 5'h10
  } ubt_state_type;

endpackage

`default_nettype wire

// ==== rtl/ubt_baseclk.sv ====
// Purpose: Base clock tick generator for the serial transmitter
// Assumes: Timer output is synchronous to clk
// Notes: Produces a one-cycle enable at the selected base clock rate
`timescale 1ns/10ps
`default_nettype none

module ubt_baseclk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [3:0] sel,
  input wire logic timer_out,
  output logic tick
);
  import ubt_pkg::*;

  logic [DIV_CNT_W-1:0] div_cnt;
  logic timer_q;

  function automatic logic [DIV_CNT_W-1:0] div_mask(input logic [3:0] code);
    logic [DIV_CNT_W:0] one_hot;
    one_hot = (DIV_CNT_W + 1)'(1) << code;
    return DIV_CNT_W'(one_hot - (DIV_CNT_W + 1)'(1));
  endfunction

  // Free-running prescaler of the peripheral clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= div_cnt + DIV_CNT_W'(1);
    end
  end

  // Timer output taken straight from the timer, not from its pin
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_q <= 1'b0;
    end else begin
      timer_q <= timer_out;
    end
  end

  always_comb begin
    if (sel <= SEL_DIV_MAX) begin
      tick = ((div_cnt & div_mask(sel)) == div_mask(sel));
    end else if (sel == SEL_TIMER) begin
      tick = timer_out & ~timer_q;
    end else begin
      tick = 1'b0;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  chk_code0_every:
    assert property (sel == 4'h0 |-> tick)
    else $error("Undivided base clock missed a tick");
  chk_bad_code_quiet:
    assert property (sel > SEL_TIMER |-> !tick)
    else $error("Prohibited select produced a tick");
  chk_timer_edge:
    assert property (sel == SEL_TIMER && tick |-> timer_out && !$past(timer_out))
    else $error("Timer tick without rising timer output");
  chk_div2_alternate:
    assert property (sel == 4'h1 && $past(sel) == 4'h1 && tick |-> !$past(tick))
    else $error("Divide by two ticked twice in a row");

endmodule

`default_nettype wire

// ==== rtl/ubt_top.sv ====
// Purpose: Serial transmitter with base clock select and register port
// Assumes: Bus strobes are one cycle, never both at once
// Notes: Read data stands only in the cycle after the read strobe
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module ubt_top (
  input wire logic CLK,
  input wire logic RST_N,
  input wire ubt_pkg::ubt_bus_type BUS,
  output logic [7:0] RDATA,
  input wire logic AUX_TIMER_OUT,
  output logic TXD,
  output logic TX_BUSY,
  output logic IRQ
);
  import ubt_pkg::*;

  logic [3:0] clk_sel;
  ubt_mode_type mode;
  logic [7:0] divisor;
  logic [7:0] txb;
  logic [1:0] sts;
  logic [1:0] next_sts;
  logic [1:0] mask;
  logic tx_en;
  logic tick;
  logic [7:0] bit_cnt;
  logic bit_end;
  ubt_state_type state;
  logic [7:0] shifter;
  logic [2:0] idx;
  logic par_bit;
  logic stop_two;
  logic stop_left;
  logic par_on;
  logic frame_end;
  logic wr_sel;
  logic wr_mode;
  logic wr_txb;
  logic wr_div;
  logic wr_stat;
  logic wr_mask;
  logic load;
  logic overrun;
  ubt_mode_type wmode;

  function automatic logic calc_parity(input ubt_parity_type p, input logic [7:0] d);
    case (p)
      PAR_ZERO: return 1'b0;
      PAR_ODD: return ~(^d);
      PAR_EVEN: return ^d;
      default: return 1'b0;
    endcase
  endfunction

  assign wmode = ubt_mode_type'(BUS.wdata);
  assign wr_sel = BUS.wr && BUS.addr == ADDR_CLK_SEL;
  assign wr_mode = BUS.wr && BUS.addr == ADDR_MODE;
  assign wr_txb = BUS.wr && BUS.addr == ADDR_TXB;
  assign wr_div = BUS.wr && BUS.addr == ADDR_DIV;
  assign wr_stat = BUS.wr && BUS.addr == ADDR_STAT;
  assign wr_mask = BUS.wr && BUS.addr == ADDR_MASK;

  // A buffer write starts a frame only when enabled and idle
  assign load = wr_txb && tx_en && state == ST_IDLE;
  assign overrun = wr_txb && tx_en && state != ST_IDLE;

  ubt_baseclk u_baseclk (
    .clk(CLK),
    .rst_n(RST_N),
    .sel(clk_sel),
    .timer_out(AUX_TIMER_OUT),
    .tick(tick)
  );

  // Base clock select, upper bits not stored
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      clk_sel <= CLK_SEL_RST;
    end else if (wr_sel) begin
      clk_sel <= BUS.wdata[3:0];
    end
  end

  // Mode register, reserved bits kept at zero
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mode <= ubt_mode_type'(MODE_RST);
    end else if (wr_mode) begin
      mode <= '{power: wmode.power, txe: wmode.txe, rsvd_hi: 1'b0,
                parity: wmode.parity, stop2: wmode.stop2, rsvd_lo: 2'h0};
    end
  end

  // Enable needs power already set before transmit enable is written
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      tx_en <= 1'b0;
    end else if (wr_mode) begin
      tx_en <= wmode.power & wmode.txe & mode.power;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      divisor <= DIV_RST;
    end else if (wr_div) begin
      divisor <= BUS.wdata;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask <= MASK_RST;
    end else if (wr_mask) begin
      mask <= BUS.wdata[1:0];
    end
  end

  // Buffer holds the last accepted byte
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      txb <= 8'h00;
    end else if (load) begin
      txb <= BUS.wdata;
    end
  end

  // Bit timer: each bit lasts divisor plus one base ticks
  assign bit_end = tick && bit_cnt == divisor;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bit_cnt <= 8'h00;
    end else if (load || state == ST_IDLE) begin
      bit_cnt <= 8'h00;
    end else if (bit_end) begin
      bit_cnt <= 8'h00;
    end else if (tick) begin
      bit_cnt <= bit_cnt + 8'h01;
    end
  end

  assign frame_end = state == ST_STOP && bit_end && !stop_left;

  // Frame sequencer
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      TXD <= 1'b1;
      shifter <= 8'h00;
      idx <= 3'h0;
      par_bit <= 1'b0;
      stop_two <= 1'b0;
      stop_left <= 1'b0;
      par_on <= 1'b0;
    end else if (!tx_en) begin
      state <= ST_IDLE;
      TXD <= 1'b1;
    end else begin
      case (state)
        ST_IDLE: begin
          TXD <= 1'b1;
          if (load) begin
            state <= ST_START;
            shifter <= BUS.wdata;
            par_bit <= calc_parity(mode.parity, BUS.wdata);
            stop_two <= mode.stop2;
            par_on <= mode.parity != PAR_NONE;
            TXD <= 1'b0;
          end
        end
        ST_START: begin
          if (bit_end) begin
            state <= ST_DATA;
            idx <= 3'h0;
            TXD <= shifter[0];
            shifter <= {1'b0, shifter[7:1]};
          end
        end
        ST_DATA: begin
          if (bit_end) begin
            if (idx == LAST_DATA_IDX) begin
              if (par_on) begin
                state <= ST_PARITY;
                TXD <= par_bit;
              end else begin
                state <= ST_STOP;
                TXD <= 1'b1;
                stop_left <= stop_two;
              end
            end else begin
              idx <= idx + 3'h1;
              TXD <= shifter[0];
              shifter <= {1'b0, shifter[7:1]};
            end
          end
        end
        ST_PARITY: begin
          if (bit_end) begin
            state <= ST_STOP;
            TXD <= 1'b1;
            stop_left <= stop_two;
          end
        end
        ST_STOP: begin
          if (bit_end) begin
            if (stop_left) begin
              stop_left <= 1'b0;
            end else begin
              state <= ST_IDLE;
              TXD <= 1'b1;
            end
          end
        end
        default: begin
          state <= ST_IDLE;
          TXD <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      TX_BUSY <= 1'b0;
    end else begin
      TX_BUSY <= load || (tx_en && state != ST_IDLE && !frame_end);
    end
  end

  // Sticky events, a set beats a write-one clear in the same cycle
  always_comb begin
    next_sts = sts;
    if (wr_stat) begin
      next_sts = sts & ~BUS.wdata[1:0];
    end
    if (frame_end) begin
      next_sts[STAT_DONE_BIT] = 1'b1;
    end
    if (overrun) begin
      next_sts[STAT_OVR_BIT] = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      sts <= STAT_RST;
    end else begin
      sts <= next_sts;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(next_sts & mask);
    end
  end

  // Read data only in the cycle after the strobe
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else if (BUS.rd) begin
      case (BUS.addr)
        ADDR_CLK_SEL: RDATA <= {4'h0, clk_sel};
        ADDR_MODE: RDATA <= mode;
        ADDR_TXB: RDATA <= txb;
        ADDR_DIV: RDATA <= divisor;
        ADDR_STAT: RDATA <= {TX_BUSY, 5'h00, sts};
        ADDR_MASK: RDATA <= {6'h00, mask};
        default: RDATA <= 8'h00;
      endcase
    end else begin
      RDATA <= 8'h00;
    end
  end

  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  chk_sel_upper_zero:
    assert property (BUS.rd && BUS.addr == ADDR_CLK_SEL |=> RDATA[7:4] == 4'h0)
    else $error("Clock select upper bits not zero");
  chk_idle_high:
    assert property (state == ST_IDLE && $past(state) == ST_IDLE |-> TXD)
    else $error("Line not high while idle");
  chk_start_low:
    assert property (state == ST_START |-> !TXD)
    else $error("Start bit not low");
  chk_stop_high:
    assert property (state == ST_STOP |-> TXD)
    else $error("Stop bit not high");
  chk_write_starts:
    assert property (load |=> state == ST_START && !TXD)
    else $error("Buffer write did not start a frame");
  chk_disabled_ignores:
    assert property (wr_txb && !tx_en && state == ST_IDLE |=> state == ST_IDLE)
    else $error("Frame started while disabled");
  chk_enable_order:
    assert property ($rose(tx_en) |-> $past(mode.power) && mode.txe)
    else $error("Enabled without power set first");
  chk_shift_load:
    assert property (load |=> shifter == $past(BUS.wdata))
    else $error("Shift register not loaded from buffer write");
  chk_first_data:
    assert property (state == ST_START && bit_end |=> TXD == $past(shifter[0]))
    else $error("First data bit is not the low bit");
  chk_done_flag:
    assert property (frame_end |=> sts[STAT_DONE_BIT] && state == ST_IDLE)
    else $error("Completion not flagged at end of stop bit");
  chk_irq_follows:
    assert property (frame_end && mask[STAT_DONE_BIT] |=> IRQ)
    else $error("Completion interrupt not raised");
  chk_stays_idle:
    assert property (state == ST_IDLE && !load |=> state == ST_IDLE)
    else $error("Left idle without a buffer write");
  chk_parity_bit:
    assert property (state == ST_PARITY |-> TXD == par_bit)
    else $error("Parity bit wrong");
  chk_busy_refused:
    assert property (overrun |=> sts[STAT_OVR_BIT] && txb == $past(txb))
    else $error("Write while busy was not refused");
  chk_rdata_idle:
    assert property (!BUS.rd |=> RDATA == 8'h00)
    else $error("Read data stood without a read");

  cov_frame_parity:
    cover property (state == ST_PARITY ##[1:1000] frame_end);
  cov_two_stop:
    cover property (state == ST_STOP && stop_left ##[1:1000] frame_end);
  cov_timer_clock:
    cover property (clk_sel == SEL_TIMER && load);
  cov_overrun:
    cover property (overrun);

endmodule

`default_nettype wire

// ==== tb/ubt_rx_model.sv ====
// Purpose: Far-end asynchronous receiver watching the transmit line
// Assumes: Bit length in clock cycles is given by the bench
// Notes: Samples mid-bit, collects 8 data bits and 3 following bits
`timescale 1ns/10ps
`default_nettype none

module ubt_rx_model (
  input wire logic clk,
  input wire logic line,
  input wire logic [15:0] bit_cyc,
  output var logic [10:0] frame,
  output var logic [7:0] count
);
  initial begin
    frame = 11'h000;
    count = 8'h00;
    forever begin
      @(posedge clk);
      // A low level on an idle line is a start bit
      if (line === 1'b0) begin
        repeat (bit_cyc / 2) @(posedge clk);
        // LSB first data, then parity and stop positions
        for (int k = 0; k < 11; k++) begin
          repeat (bit_cyc) @(posedge clk);
          frame[k] = line;
        end
        count = count + 8'h01;
        while (line !== 1'b1) @(posedge clk);
      end
    end
  end
endmodule

`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: Self-checking bench for the serial base clock and transmitter
// Assumes: Register port with one-cycle strobes, read data one cycle later
// Notes: Aux timer is modelled here; far end is the receiver model
`timescale 1ns/10ps
`default_nettype none

module tb_top;
  import ubt_pkg::*;
  logic clk;
  logic rst_n;
  ubt_bus_type bus;
  logic aux;
  logic tmr_run;
  logic tmr_tog;
  logic [1:0] tmr_cnt;
  logic [15:0] bit_cyc;
  wire logic [7:0] rdata;
  wire logic txd;
  wire logic busy;
  wire logic irq;
  wire logic [10:0] rx_frame;
  wire logic [7:0] rx_count;
  int bad_count = 0;
  int n_checks = 0;

  ubt_top u_ubt_top (.CLK(clk), .RST_N(rst_n), .BUS(bus), .RDATA(rdata),
    .AUX_TIMER_OUT(aux), .TXD(txd), .TX_BUSY(busy), .IRQ(irq));
  ubt_rx_model u_ubt_rx_model (.clk(clk), .line(txd), .bit_cyc(bit_cyc),
    .frame(rx_frame), .count(rx_count));

  // Aux timer counts once started and toggles only when toggling is on
  always @(posedge clk) begin
    if (tmr_run) begin
      tmr_cnt <= (tmr_cnt == 2'h2) ? 2'h0 : tmr_cnt + 2'h1;
      // Equal high and low halves of three cycles each
      if (tmr_tog && tmr_cnt == 2'h2) begin
        aux <= ~aux;
      end
    end
  end

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [10:0] s, input logic [10:0] e);
    n_checks++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus.wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [15:0] a, output logic [7:0] v);
    @(posedge clk);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus.rd <= 1'b0;
    #1 v = rdata;
  endtask

  task automatic wait_txd(input logic lv, output int n);
    n = 0;
    #1;
    while (txd !== lv && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 20000) begin
      bad_count++;
    end
  endtask

  function automatic logic [10:0] exp_frame(input logic [7:0] d, input logic [1:0] p);
    logic pb;
    pb = (p == 2'h1) ? 1'b0 : (p == 2'h2) ? ~^d : ^d;
    return (p == 2'h0) ? {3'b111, d} : {2'b11, pb, d};
  endfunction

  // One frame: start timing, busy length, interrupt, and received bits
  task automatic send_chk(input logic [7:0] d, input logic [1:0] p, input logic s2,
                          input logic [7:0] dv, input logic ei);
    int n;
    int e;
    logic [7:0] f0;
    wr_reg(ADDR_MODE, {2'b11, 1'b0, p, s2, 2'b00});
    wr_reg(ADDR_DIV, dv);
    bit_cyc = 16'(dv) + 16'h0001;
    e = (10 + int'(p != 2'h0) + int'(s2)) * (int'(dv) + 1);
    f0 = rx_count;
    wr_reg(ADDR_TXB, d);
    #1 chk(txd, 1'b0);
    n = 0;
    while (busy === 1'b1 && n < 500) begin
      @(posedge clk);
      #1 n++;
    end
    chk(11'(n), 11'(e));
    chk(irq, ei);
    n = 0;
    while (rx_count === f0 && n < 200) begin
      @(posedge clk);
      #1 n++;
    end
    if (n >= 200) begin
      bad_count++;
    end
    chk(rx_frame, exp_frame(d, p));
    wr_reg(ADDR_STAT, 8'h03);
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    complete_run;
  end

  initial begin
    int n;
    int c;
    logic [7:0] v;
    rst_n = 1'b0;
    bus = '0;
    aux = 1'b0;
    tmr_run = 1'b0;
    tmr_tog = 1'b0;
    tmr_cnt = 2'h0;
    bit_cyc = 16'h0001;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_reg(ADDR_CLK_SEL, v);
    chk(v, 8'h00);
    wr_reg(ADDR_CLK_SEL, 8'hfb);
    rd_reg(ADDR_CLK_SEL, v);
    chk(v, 8'h0b);
    wr_reg(ADDR_CLK_SEL, 8'h00);
    rd_reg(16'hff5f, v);
    chk(v, 8'h00);
    wr_reg(ADDR_MASK, 8'h03);
    // Power and enable together from off must not enable
    wr_reg(ADDR_MODE, 8'hc0);
    wr_reg(ADDR_TXB, 8'h5a);
    #1 chk(busy, 1'b0);
    wr_reg(ADDR_MODE, 8'h80);
    send_chk(8'ha5, 2'h0, 1'b0, 8'h00, 1'b1);
    repeat (20) @(posedge clk);
    #1 chk(txd, 1'b1);
    chk(busy, 1'b0);
    chk(irq, 1'b0);
    for (c = 0; c < 4; c++) begin
      send_chk(8'h3c ^ (8'(c) * 8'h25), 2'(c), c[0], 8'h03, 1'b1);
    end
    // Second write while busy is refused and flagged
    wr_reg(ADDR_TXB, 8'h11);
    wr_reg(ADDR_TXB, 8'h22);
    rd_reg(ADDR_STAT, v);
    chk(v, 8'h82);
    chk(irq, 1'b1);
    wait_idle;
    rd_reg(ADDR_TXB, v);
    chk(v, 8'h11);
    rd_reg(ADDR_STAT, v);
    chk(v, 8'h03);
    wr_reg(ADDR_STAT, 8'h03);
    wr_reg(ADDR_MASK, 8'h00);
    send_chk(8'h77, 2'h0, 1'b0, 8'h00, 1'b0);
    // Bit length for base clock codes 1 to 10, then the timer output
    for (c = 1; c < 12; c++) begin
      if (c == 11) begin
        @(posedge clk);
        tmr_run <= 1'b1;
        repeat (4) @(posedge clk);
        tmr_tog <= 1'b1;
      end
      wr_reg(ADDR_CLK_SEL, 8'(c));
      wr_reg(ADDR_TXB, 8'h55);
      wait_txd(1'b1, n);
      wait_txd(1'b0, n);
      chk(11'(n), (c == 11) ? 11'h006 : 11'(1 << c));
      wait_idle;
    end
    // Prohibited code gives no ticks; disabling aborts the frame
    wr_reg(ADDR_CLK_SEL, 8'h0c);
    wr_reg(ADDR_TXB, 8'h0f);
    repeat (50) @(posedge clk);
    #1 chk(txd, 1'b0);
    chk(busy, 1'b1);
    wr_reg(ADDR_MODE, 8'h80);
    @(posedge clk);
    #1 chk(txd, 1'b1);
    complete_run;
  end
endmodule

`default_nettype wire
